// [compat_ctrl.sv]
// Compatibility flag, control bit and fault logic of the core.
// Assumes a classic Wishbone master and a decoder on the same clock.
//
// Functional notes
// - Test register moves raise invalid opcode
// - Reserved opcodes always raise invalid opcode
// - Virtual interrupt flag 19, pending 20
// - Alignment check flag bit 18 writable
// - Query permit flag bit 21 writable
// - Stack pointer push stores pre-decrement value
// - Real mode flags image: bit15 clear
// - Extension type bit fixed at one
// - Numeric error bit selects vector 16
// - Numeric error bit clears on reset
// - Monitor plus task bit trap waits
// - Later instruction additions decode as valid
// - Reserved extended control change gives fault
//
// Added by the designer: the register addresses and register access over Wishbone.
`default_nettype none
module compat_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dec_valid_i,
  input wire compat_pkg::op_class_t dec_class_i,
  input wire logic sp_push_i,
  input wire logic [31:0] stack_pointer_i,
  input wire logic flags_push_i,
  input wire logic real_mode_i,
  input wire logic fpu_pend_i,
  output logic fault_valid_o,
  output logic [7:0] fault_vector_o,
  output logic exec_ok_o,
  output logic push_valid_o,
  output logic [31:0] push_data_o,
  output logic fpu_err_o,
  output logic irq_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic ack_r;
  logic [31:0] flags_r;
  logic [31:0] ctrl0_r;
  logic [31:0] ext_ctrl_r;
  logic [compat_pkg::IRQ_W-1:0] stat_r;
  logic [compat_pkg::IRQ_W-1:0] mask_r;
  logic [compat_pkg::IRQ_W-1:0] stat_nxt;
  logic gp_pend_r;
  logic ext_err_r;
  logic [31:0] rd_r;
  logic fault_r;
  logic [7:0] vec_r;
  logic ok_r;
  logic push_v_r;
  logic [31:0] push_r;
  logic irq_r;

  function automatic logic [31:0] apply_sel(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Decode and FPU helpers
  // ----------------------------------------
  decode_if d ();
  assign d.valid = dec_valid_i;
  assign d.cls = dec_class_i;
  assign d.mon_bit = ctrl0_r[compat_pkg::MON_COPROC_POS];
  assign d.task_bit = ctrl0_r[compat_pkg::TASK_SWITCHED_POS];
  assign d.num_err_bit = ctrl0_r[compat_pkg::NUM_ERR_POS];
  assign d.fpu_pend = fpu_pend_i;
  opcode_screen u_screen (
    .d(d.screen)
  );
  fpu_route u_route (
    .d(d.route)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr_go = req & wb_we_i;
  wire rd_go = req & ~wb_we_i;
  wire hit_flags = wb_adr_i == compat_pkg::FLAGS_OFS;
  wire hit_ctrl0 = wb_adr_i == compat_pkg::CTRL0_OFS;
  wire hit_ext = wb_adr_i == compat_pkg::EXT_CTRL_OFS;
  wire hit_stat = wb_adr_i == compat_pkg::IRQ_STAT_OFS;
  wire hit_mask = wb_adr_i == compat_pkg::IRQ_MASK_OFS;
  wire [31:0] rd_val = hit_flags ? flags_r :
                       hit_ctrl0 ? ctrl0_r :
                       hit_ext ? ext_ctrl_r :
                       hit_stat ? {27'h0, stat_r} :
                       hit_mask ? {27'h0, mask_r} : 32'h0;
  wire [31:0] flags_nxt = apply_sel(flags_r, wb_dat_i, wb_sel_i) & compat_pkg::FLAGS_WMASK;
  wire [31:0] ctrl0_nxt = apply_sel(ctrl0_r, wb_dat_i, wb_sel_i) | (32'h1 << compat_pkg::EXT_TYPE_POS);
  wire [31:0] ext_cand = apply_sel(ext_ctrl_r, wb_dat_i, wb_sel_i);
  wire ext_bad = |((ext_cand ^ ext_ctrl_r) & ~compat_pkg::EXT_CTRL_IMPL);
  wire wr_ext_bad = wr_go & hit_ext & ext_bad;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rd_r <= 32'h0;
    end else begin
      ack_r <= req;
      if (rd_go) begin
        rd_r <= rd_val;
      end
    end
  end

  // ----------------------------------------
  // Architectural registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= compat_pkg::FLAGS_RESET;
      ctrl0_r <= compat_pkg::CTRL0_RESET;
      ext_ctrl_r <= 32'h0;
      mask_r <= 5'h00;
    end else if (wr_go) begin
      if (hit_flags) begin
        flags_r <= flags_nxt;
      end else if (hit_ctrl0) begin
        ctrl0_r <= ctrl0_nxt;
      end else if (hit_ext && !ext_bad) begin
        ext_ctrl_r <= ext_cand;
      end else if (hit_mask) begin
        mask_r <= wb_dat_i[compat_pkg::IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Fault selection
  // ----------------------------------------
  // A refused bus write waits in gp_pend_r for a cycle with no instruction,
  // so its fault never shares a cycle with an execute or a decode fault.
  wire dec_fault = d.invalid | d.dev_na | d.int_report;
  wire gp_take = gp_pend_r & ~d.valid;
  wire [7:0] vec_sel = d.invalid ? compat_pkg::VEC_INVALID_OP :
                       d.dev_na ? compat_pkg::VEC_DEV_NA :
                       d.int_report ? compat_pkg::VEC_FPU_ERR :
                       compat_pkg::VEC_GEN_PROT;
  wire ext_rise = d.ext_err & ~ext_err_r;
  wire [compat_pkg::IRQ_W-1:0] ev = {ext_rise, d.int_report, gp_take, d.dev_na, d.invalid};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_r <= 1'b0;
      vec_r <= 8'h00;
      ok_r <= 1'b0;
      gp_pend_r <= 1'b0;
    end else begin
      fault_r <= dec_fault | gp_take;
      vec_r <= (dec_fault | gp_take) ? vec_sel : 8'h00;
      ok_r <= d.accept & ~d.dev_na & ~d.int_report;
      gp_pend_r <= wr_ext_bad | (gp_pend_r & ~gp_take);
    end
  end

  // ----------------------------------------
  // Stack images
  // ----------------------------------------
  wire [31:0] flags_img = real_mode_i ? (flags_r & ~(32'h1 << compat_pkg::FLAGS_RSVD15_POS)) : flags_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_v_r <= 1'b0;
      push_r <= 32'h0;
    end else begin
      push_v_r <= sp_push_i | flags_push_i;
      if (sp_push_i) begin
        push_r <= stack_pointer_i;
      end else if (flags_push_i) begin
        push_r <= flags_img;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // New events win over the read-clear in the same cycle.
  assign stat_nxt = ((rd_go && hit_stat) ? 5'h00 : stat_r) | ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= 5'h00;
      ext_err_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      ext_err_r <= d.ext_err;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
  assign fault_valid_o = fault_r;
  assign fault_vector_o = vec_r;
  assign exec_ok_o = ok_r;
  assign push_valid_o = push_v_r;
  assign push_data_o = push_r;
  assign fpu_err_o = ext_err_r;
  assign irq_o = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TEST_MOVE_UD: assert property (
    dec_valid_i && dec_class_i == compat_pkg::CLS_TEST_REG_MOVE
    |=> fault_valid_o && fault_vector_o == 8'h06 && !exec_ok_o)
    else $error("test register move not refused");
  AST_RESERVED_UD: assert property (
    dec_valid_i && dec_class_i == compat_pkg::CLS_RESERVED
    |=> fault_vector_o == 8'h06 && !exec_ok_o)
    else $error("reserved opcode not refused");
  AST_VIRT_BITS: assert property (
    wr_go && hit_flags && wb_sel_i[2]
    |=> flags_r[20:19] == $past(wb_dat_i[20:19]))
    else $error("virtual interrupt bits not stored");
  AST_ALIGN_BIT: assert property (
    wr_go && hit_flags && wb_sel_i[2]
    |=> flags_r[18] == $past(wb_dat_i[18]))
    else $error("alignment check bit not stored");
  AST_QUERY_BIT: assert property (
    wr_go && hit_flags && wb_sel_i[2]
    |=> flags_r[21] == $past(wb_dat_i[21]))
    else $error("query permit bit not stored");
  AST_SP_PUSH: assert property (
    sp_push_i |=> push_valid_o && push_data_o == $past(stack_pointer_i))
    else $error("stack pointer push value wrong");
  AST_REAL_IMAGE: assert property (
    flags_push_i && !sp_push_i && real_mode_i
    |=> !push_data_o[15] && push_data_o[14:12] == $past(flags_r[14:12]))
    else $error("real mode flags image wrong");
  AST_EXT_TYPE: assert property (
    ##1 ctrl0_r[4])
    else $error("extension type bit not one");
  AST_INT_REPORT: assert property (
    dec_valid_i && dec_class_i == compat_pkg::CLS_FPU_WAITING && fpu_pend_i
    && ctrl0_r[5] && !(ctrl0_r[1] && ctrl0_r[3])
    |=> fault_valid_o && fault_vector_o == 8'h10)
    else $error("internal fpu report missing");
  AST_NE_RESET: assert property (
    $fell(rst_i) |-> !ctrl0_r[5] && ctrl0_r[4])
    else $error("numeric error bit not cleared");
  AST_DEV_NA: assert property (
    dec_valid_i && dec_class_i == compat_pkg::CLS_FPU_WAITING
    && ctrl0_r[1] && ctrl0_r[3] |=> fault_vector_o == 8'h07)
    else $error("device not available missing");
  AST_ADDED_OK: assert property (
    dec_valid_i && dec_class_i == compat_pkg::CLS_COMPARE_EXCHANGE
    |=> exec_ok_o && !fault_valid_o)
    else $error("added instruction refused");
  AST_GP_WRITE: assert property (
    wr_ext_bad |=> gp_pend_r && ext_ctrl_r == $past(ext_ctrl_r))
    else $error("reserved extended bit change accepted");
  AST_EXT_ERR: assert property (
    fpu_pend_i && !ctrl0_r[5] |=> fpu_err_o)
    else $error("external fpu error not held");
  AST_EXT_ERR_LOW: assert property (
    !fpu_pend_i || ctrl0_r[5] |=> !fpu_err_o)
    else $error("external fpu error without pending error");

  COV_TEST_MOVE: cover property (dec_valid_i && dec_class_i == compat_pkg::CLS_TEST_REG_MOVE);
  COV_DEV_NA: cover property (fault_valid_o && fault_vector_o == 8'h07);
  COV_GP: cover property (gp_take);
  COV_EXT_ERR: cover property ($rose(fpu_err_o));
endmodule
`default_nettype wire

// [compat_pkg.sv]
// Constants shared by the compatibility flag and fault control block.
// Assumes a 32-bit core with a classic Wishbone register port.
`default_nettype none
package compat_pkg;
  // ----------------------------------------
  // Decoder instruction classes
  // ----------------------------------------
  typedef enum logic [3:0] {
    CLS_PLAIN,
    CLS_TEST_REG_MOVE,
    CLS_RESERVED,
    CLS_BYTE_SWAP,
    CLS_EXCHANGE_ADD,
    CLS_COMPARE_EXCHANGE,
    CLS_CACHE_INVALIDATE,
    CLS_CACHE_FLUSH_INVALIDATE,
    CLS_TRANSLATION_ENTRY_INVALIDATE,
    CLS_FPU_WAITING
  } op_class_t;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] CTRL0_OFS = 8'h04;
  localparam logic [7:0] EXT_CTRL_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int ALIGN_CHECK_POS = 18;
  localparam int VIRT_INTR_FLAG_POS = 19;
  localparam int VIRT_INTR_PEND_POS = 20;
  localparam int QUERY_PERMIT_POS = 21;
  localparam int FLAGS_RSVD15_POS = 15;
  localparam logic [31:0] FLAGS_WMASK = 32'h003F_7FFF;
  localparam int MON_COPROC_POS = 1;
  localparam int TASK_SWITCHED_POS = 3;
  localparam int EXT_TYPE_POS = 4;
  localparam int NUM_ERR_POS = 5;
  localparam logic [31:0] CTRL0_RESET = 32'h0000_0010;
  localparam logic [31:0] EXT_CTRL_IMPL = 32'h0000_01FF;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  // ----------------------------------------
  // Fault vectors and status bit layout
  // ----------------------------------------
  localparam logic [7:0] VEC_INVALID_OP = 8'h06;
  localparam logic [7:0] VEC_DEV_NA = 8'h07;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0D;
  localparam logic [7:0] VEC_FPU_ERR = 8'h10;
  localparam int IRQ_W = 5;
endpackage
`default_nettype wire

// [decode_if.sv]
// Carrier between the control core and its decode and FPU routing helpers.
// Assumes all members live on the single core clock.
`default_nettype none
interface decode_if;
  logic valid;
  compat_pkg::op_class_t cls;
  logic invalid;
  logic accept;
  logic fwait;
  logic mon_bit;
  logic task_bit;
  logic num_err_bit;
  logic fpu_pend;
  logic dev_na;
  logic int_report;
  logic ext_err;
  modport screen (input valid, cls, output invalid, accept, fwait);
  modport route (input fwait, mon_bit, task_bit, num_err_bit, fpu_pend,
                 output dev_na, int_report, ext_err);
  modport ctrl (output valid, cls, mon_bit, task_bit, num_err_bit, fpu_pend,
                input invalid, accept, fwait, dev_na, int_report, ext_err);
endinterface
`default_nettype wire

// [opcode_screen.sv]
// Opcode screen: classifies each decoded instruction as legal or invalid.
// Assumes the decoder presents one class per valid cycle.
`default_nettype none
module opcode_screen (
  decode_if.screen d
);
  wire is_test_move = d.cls == compat_pkg::CLS_TEST_REG_MOVE;
  wire is_reserved = d.cls == compat_pkg::CLS_RESERVED;
  wire is_added = d.cls inside {compat_pkg::CLS_BYTE_SWAP,
    compat_pkg::CLS_EXCHANGE_ADD, compat_pkg::CLS_COMPARE_EXCHANGE,
    compat_pkg::CLS_CACHE_INVALIDATE, compat_pkg::CLS_CACHE_FLUSH_INVALIDATE,
    compat_pkg::CLS_TRANSLATION_ENTRY_INVALIDATE};
  wire is_plain = d.cls == compat_pkg::CLS_PLAIN;
  wire is_fpu = d.cls == compat_pkg::CLS_FPU_WAITING;
  // Unlisted class codes are refused like reserved encodings
  wire is_legal = is_plain | is_added | is_fpu;
  assign d.invalid = d.valid & (is_test_move | is_reserved | ~is_legal);
  assign d.accept = d.valid & is_legal;
  assign d.fwait = d.valid & is_fpu;
endmodule
`default_nettype wire

// [fpu_route.sv]
// FPU error routing and waiting-instruction trap selection.
// Assumes fpu_pend stays high until the exception is handled.
`default_nettype none
module fpu_route (
  decode_if.route d
);
  assign d.dev_na = d.fwait & d.mon_bit & d.task_bit;
  assign d.int_report = d.fwait & ~d.dev_na & d.num_err_bit & d.fpu_pend;
  assign d.ext_err = ~d.num_err_bit & d.fpu_pend;
endmodule
`default_nettype wire

// [compat_ctrl_bench.sv]
// Self-checking bench for the compatibility flag and fault control block.
// Assumes one core clock, a classic Wishbone port answering after one cycle, pulse results.
`default_nettype none
module compat_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and result notes
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic dec_valid_i = 1'b0;
  compat_pkg::op_class_t dec_class_i = compat_pkg::CLS_PLAIN;
  logic sp_push_i = 1'b0;
  logic [31:0] stack_pointer_i = 32'h0000_0000;
  logic flags_push_i = 1'b0;
  logic real_mode_i = 1'b0;
  logic fpu_pend_i = 1'b0;
  logic fault_valid_o;
  logic [7:0] fault_vector_o;
  logic exec_ok_o;
  logic push_valid_o;
  logic [31:0] push_data_o;
  logic fpu_err_o;
  logic irq_o;
  logic [31:0] rd_q[$];
  logic [7:0] dec_q[$];
  logic [31:0] push_q[$];
  logic [31:0] r;
  logic [7:0] e;
  logic [7:0] seen_v;
  int miscompares = 0;
  int tests_run = 0;
  int seed_val;
  always #50 clk_i = ~clk_i;
  // ----------------------------------------
  // Design under test
  // ----------------------------------------
  compat_ctrl compat_ctrl_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .dec_valid_i(dec_valid_i),
    .dec_class_i(dec_class_i),
    .sp_push_i(sp_push_i),
    .stack_pointer_i(stack_pointer_i),
    .flags_push_i(flags_push_i),
    .real_mode_i(real_mode_i),
    .fpu_pend_i(fpu_pend_i),
    .fault_valid_o(fault_valid_o),
    .fault_vector_o(fault_vector_o),
    .exec_ok_o(exec_ok_o),
    .push_valid_o(push_valid_o),
    .push_data_o(push_data_o),
    .fpu_err_o(fpu_err_o),
    .irq_o(irq_o)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // For a read, dat is the value the read must return
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    if (!we) rd_q.push_back(dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    check("bus answer", 32'(n < 50), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Pulses are held across calls so back-to-back requests never re-assign in one step
  task automatic dec(input compat_pkg::op_class_t c, input logic [7:0] x);
    @(posedge clk_i);
    dec_valid_i <= 1'b1;
    dec_class_i <= c;
    dec_q.push_back(x);
  endtask
  task automatic psh(input logic sp, input logic fl, input logic [31:0] v, input logic [31:0] x);
    @(posedge clk_i);
    sp_push_i <= sp;
    flags_push_i <= fl;
    stack_pointer_i <= v;
    push_q.push_back(x);
  endtask
  task automatic idle();
    @(posedge clk_i);
    dec_valid_i <= 1'b0;
    sp_push_i <= 1'b0;
    flags_push_i <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  // A result with no note gets a note that cannot match, so it is counted
  always @(negedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) rd_q.push_back(~wb_dat_o);
      check("read data", wb_dat_o, rd_q.pop_front());
    end
    if (fault_valid_o === 1'b1 || exec_ok_o === 1'b1) begin
      seen_v = (exec_ok_o === 1'b1) ? 8'hFF : fault_vector_o;
      if (dec_q.size() == 0) dec_q.push_back(~seen_v);
      check("decode result", 32'(seen_v), 32'(dec_q.pop_front()));
    end
    if (push_valid_o === 1'b1) begin
      if (push_q.size() == 0) push_q.push_back(~push_data_o);
      check("push image", push_data_o, push_q.pop_front());
    end
  end
  // Real run is a few hundred cycles; this allows about 4000
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed_val = $urandom(32'hCCD4);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, compat_pkg::CTRL0_OFS, 32'h0000_0010);
    wb(1'b0, compat_pkg::FLAGS_OFS, 32'h0000_0000);
    wb(1'b0, compat_pkg::EXT_CTRL_OFS, 32'h0000_0000);
    wb(1'b0, compat_pkg::IRQ_STAT_OFS, 32'h0000_0000);
    wb(1'b0, 8'h14, 32'h0000_0000);
    wb(1'b1, compat_pkg::FLAGS_OFS, 32'hFFFF_FFFF);
    wb(1'b0, compat_pkg::FLAGS_OFS, 32'h003F_7FFF);
    for (int b = 18; b < 22; b++) begin
      wb(1'b1, compat_pkg::FLAGS_OFS, 32'h1 << b);
      wb(1'b0, compat_pkg::FLAGS_OFS, 32'h1 << b);
    end
    wb(1'b1, compat_pkg::FLAGS_OFS, 32'h0000_0000);
    wb(1'b0, compat_pkg::FLAGS_OFS, 32'h0000_0000);
    r = $urandom() | 32'h0000_8000;
    wb(1'b1, compat_pkg::FLAGS_OFS, r);
    r = r & 32'h003F_7FFF;
    wb(1'b0, compat_pkg::FLAGS_OFS, r);
    @(posedge clk_i);
    real_mode_i <= 1'b1;
    psh(1'b0, 1'b1, 32'h0000_0000, r & ~(32'h1 << 15));
    for (int i = 0; i < 4; i++) begin
      e = 8'($urandom());
      psh(1'b1, e[0], {e, 24'hFFFFFC} - 32'(i), {e, 24'hFFFFFC} - 32'(i));
    end
    idle();
    // every class, back to back, status masked
    wb(1'b1, compat_pkg::CTRL0_OFS, 32'h0000_0000);
    wb(1'b0, compat_pkg::CTRL0_OFS, 32'h0000_0010);
    wb(1'b1, compat_pkg::CTRL0_OFS, 32'h0000_000A);
    wb(1'b0, compat_pkg::CTRL0_OFS, 32'h0000_001A);
    for (int i = 0; i < 10; i++) begin
      e = 8'hFF;
      if (i == 1 || i == 2) e = 8'h06;
      if (i == 9) e = 8'h07;
      dec(compat_pkg::op_class_t'(4'(i)), e);
    end
    idle();
    check("masked irq", 32'(irq_o), 32'h0);
    wb(1'b1, compat_pkg::IRQ_MASK_OFS, 32'h0000_001F);
    repeat (2) @(negedge clk_i);
    check("irq raised", 32'(irq_o), 32'h1);
    wb(1'b0, compat_pkg::IRQ_STAT_OFS, 32'h0000_0003);
    repeat (2) @(negedge clk_i);
    check("irq cleared", 32'(irq_o), 32'h0);
    wb(1'b1, compat_pkg::CTRL0_OFS, 32'h0000_0022);
    @(posedge clk_i);
    fpu_pend_i <= 1'b1;
    dec(compat_pkg::CLS_FPU_WAITING, 8'h10);
    dec(compat_pkg::CLS_PLAIN, 8'hFF);
    idle();
    check("fpu error line", 32'(fpu_err_o), 32'h0);
    wb(1'b0, compat_pkg::IRQ_STAT_OFS, 32'h0000_0008);
    wb(1'b1, compat_pkg::CTRL0_OFS, 32'h0000_0002);
    repeat (2) @(negedge clk_i);
    check("fpu error line", 32'(fpu_err_o), 32'h1);
    dec(compat_pkg::CLS_FPU_WAITING, 8'hFF);
    idle();
    @(posedge clk_i);
    fpu_pend_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    check("fpu error line", 32'(fpu_err_o), 32'h0);
    wb(1'b0, compat_pkg::IRQ_STAT_OFS, 32'h0000_0010);
    wb(1'b1, compat_pkg::EXT_CTRL_OFS, 32'h0000_01FF);
    wb(1'b0, compat_pkg::EXT_CTRL_OFS, 32'h0000_01FF);
    dec_q.push_back(8'h0D);
    wb(1'b1, compat_pkg::EXT_CTRL_OFS, 32'h0000_03FF);
    repeat (4) @(negedge clk_i);
    wb(1'b0, compat_pkg::EXT_CTRL_OFS, 32'h0000_01FF);
    wb(1'b0, compat_pkg::IRQ_STAT_OFS, 32'h0000_0004);
    check("notes left", 32'(rd_q.size() + dec_q.size() + push_q.size()), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
